/* rtl/trcc_timer.sv */
// timer channel: run control, modes, capture and wishbone register slave
// Operation
// - prescaler run 0 halts and zeroes prescaler; 1 advances it each clock
// - counter run 0 stops and zeroes counter; 1 counts selected ticks
// - double buffer bit 7 buffers compare writes; reset leaves it off
// - start mode 0 uses own run bit; 1 follows group master run
// - idle bit 0 halts channel in idle; 1 keeps counting
// - writing 0 to software capture copies counter to capture 0; reads 1
// - capture timing 00 disables all hardware capture
// - timing 01: input 0 rise to capture 0, input 1 rise to capture 1
// - timing 10: input 0 rise to capture 0, its fall to capture 1
// - timing 11: match output rise to capture 0, fall to capture 1
// - trigger from channel 7, 8 or 9 output depending on channel number
// - clear enable 1 zeroes counter on compare 1 match; 0 does not
// - clock select: 00 pin, 01 T1, 10 T4, 11 T16 prescaler taps
// - 16-bit counter, compare and capture registers
// - synchronous group masters are channel 0 and channel 4
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module trcc_timer #(
  parameter int CHANNEL = 0,
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic idle_mode_i,
  input wire logic master_run_i,
  input wire logic capture_input_0_i,
  input wire logic capture_input_1_i,
  input wire logic channel7_match_output_i,
  input wire logic channel8_match_output_i,
  input wire logic channel9_match_output_i,
  output logic counter_run_o,
  output logic [WIDTH-1:0] count_o
);
  // ------------------------------------------------------------
  // short local copies of package constants
  // ------------------------------------------------------------
  // declared ahead of every process so that no name is used before it exists
  localparam int ENABLE_BIT_C = trcc_pkg::ENABLE_BIT;
  localparam int PRESCALER_RUN_BIT_C = trcc_pkg::PRESCALER_RUN_BIT;
  localparam int COUNTER_RUN_BIT_C = trcc_pkg::COUNTER_RUN_BIT;
  localparam int DOUBLE_BUFFER_BIT_C = trcc_pkg::DOUBLE_BUFFER_BIT;
  localparam int RESERVED_W0_BIT_C = trcc_pkg::RESERVED_W0_BIT;
  localparam int SYNC_START_BIT_C = trcc_pkg::SYNC_START_BIT;
  localparam int IDLE_RUN_BIT_C = trcc_pkg::IDLE_RUN_BIT;
  localparam int SW_CAPTURE_BIT_C = trcc_pkg::SW_CAPTURE_BIT;
  localparam int CAP_TIMING_LSB_C = trcc_pkg::CAP_TIMING_LSB;
  localparam int MATCH1_CLEAR_BIT_C = trcc_pkg::MATCH1_CLEAR_BIT;
  localparam int CLK_SEL_LSB_C = trcc_pkg::CLK_SEL_LSB;
  localparam int TAP_T4_C = trcc_pkg::TAP_T4;
  localparam int TAP_T16_C = trcc_pkg::TAP_T16;
  localparam logic [1:0] CLK_PIN_C = trcc_pkg::CLK_PIN;
  localparam logic [1:0] CLK_T1_C = trcc_pkg::CLK_T1;
  localparam logic [1:0] CLK_T4_C = trcc_pkg::CLK_T4;
  localparam logic [1:0] CLK_T16_C = trcc_pkg::CLK_T16;
  localparam logic [1:0] CAP_OFF_C = trcc_pkg::CAP_OFF;
  localparam logic [1:0] CAP_IN0_IN1_C = trcc_pkg::CAP_IN0_IN1;
  localparam logic [1:0] CAP_IN0_BOTH_C = trcc_pkg::CAP_IN0_BOTH;
  localparam logic [1:0] CAP_MATCH_C = trcc_pkg::CAP_MATCH;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic enable;
    logic prescaler_run;
    logic counter_run;
    logic double_buffer_enable;
    logic reserved_w0;
    logic sync_start_select;
    logic idle_run_enable;
    logic [1:0] capture_timing_select;
    logic match1_clear_enable;
    logic [1:0] clock_source_select;
    logic [trcc_pkg::PRESCALER_WIDTH-1:0] prescaler;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] cmp0;
    logic [WIDTH-1:0] cmp1;
    logic [WIDTH-1:0] cmp0_buf;
    logic [WIDTH-1:0] cmp1_buf;
    logic [WIDTH-1:0] cap0;
    logic [WIDTH-1:0] cap1;
    logic [1:0] in0_sync;
    logic [1:0] in1_sync;
    logic [1:0] trg_sync;
    logic [1:0] clk_sync;
    logic in0_prev;
    logic in1_prev;
    logic trg_prev;
    logic clk_prev;
  } trcc_state_t;

  trcc_state_t st;
  trcc_state_t next_st;

  // rising edge helper, used for every sampled input
  function automatic logic trcc_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : trcc_rise

  // channel-to-trigger mapping, fixed per instance
  logic trigger_src;
  always_comb begin
    if (CHANNEL <= 1) begin
      trigger_src = channel7_match_output_i;
    end else if (CHANNEL <= 4) begin
      trigger_src = channel8_match_output_i;
    end else begin
      trigger_src = channel9_match_output_i;
    end
  end

  // group masters start on their own bit; members follow the master when start mode is 1
  localparam bit IS_MASTER = (CHANNEL == 0) || (CHANNEL == 4);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic req;
  logic wr;
  logic run_eff;
  logic tick;
  logic match1;
  logic in0_c;
  logic in1_c;
  logic trg_c;
  always_comb begin
    next_st = st;
    req = cyc_i & stb_i & ~st.ack;
    wr = req & we_i & sel_i[0];
    next_st.ack = req;
    // synchronisers: first stage read only by second
    next_st.in0_sync = {st.in0_sync[0], capture_input_0_i};
    next_st.in1_sync = {st.in1_sync[0], capture_input_1_i};
    next_st.trg_sync = {st.trg_sync[0], trigger_src};
    next_st.clk_sync = {st.clk_sync[0], capture_input_0_i};
    in0_c = st.in0_sync[1];
    in1_c = st.in1_sync[1];
    trg_c = st.trg_sync[1];
    next_st.in0_prev = in0_c;
    next_st.in1_prev = in1_c;
    next_st.trg_prev = trg_c;
    next_st.clk_prev = st.clk_sync[1];
    // effective run: own bit or the group master's
    run_eff = (st.sync_start_select && !IS_MASTER) ? master_run_i : st.counter_run;
    // idle mode freezes unless allowed to run
    if (idle_mode_i && !st.idle_run_enable) begin
      run_eff = 1'b0;
    end
    // prescaler: stop and clear, freeze in idle unless allowed, otherwise free-run
    if (!st.prescaler_run) begin
      next_st.prescaler = '0;
    end else if (!(idle_mode_i && !st.idle_run_enable)) begin
      next_st.prescaler = st.prescaler + 1'b1;
    end
    // source tick select
    case (st.clock_source_select)
      CLK_PIN_C: tick = trcc_rise(st.clk_prev, st.clk_sync[1]);
      CLK_T1_C: tick = st.prescaler_run;
      CLK_T4_C: tick = st.prescaler_run && (&st.prescaler[TAP_T4_C:0]);
      CLK_T16_C: tick = st.prescaler_run && (&st.prescaler[TAP_T16_C:0]);
      default: tick = 1'b0;
    endcase
    match1 = (st.count == st.cmp1);
    // counter: stop and clear, hold when idle-frozen, clear on match, or count
    if (!run_eff) begin
      if (!st.counter_run && !(st.sync_start_select && !IS_MASTER)) begin
        next_st.count = '0;
      end else if (st.sync_start_select && !IS_MASTER && !master_run_i) begin
        next_st.count = '0;
      end
    end else if (tick) begin
      if (match1 && st.match1_clear_enable) begin
        next_st.count = '0;
        if (st.double_buffer_enable) begin
          next_st.cmp0 = st.cmp0_buf;
          next_st.cmp1 = st.cmp1_buf;
        end
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
    // hardware capture by mode
    case (st.capture_timing_select)
      CAP_IN0_IN1_C: begin
        if (trcc_rise(st.in0_prev, in0_c)) next_st.cap0 = st.count;
        if (trcc_rise(st.in1_prev, in1_c)) next_st.cap1 = st.count;
      end
      CAP_IN0_BOTH_C: begin
        if (trcc_rise(st.in0_prev, in0_c)) next_st.cap0 = st.count;
        if (trcc_rise(in0_c, st.in0_prev)) next_st.cap1 = st.count;
      end
      CAP_MATCH_C: begin
        if (trcc_rise(st.trg_prev, trg_c)) next_st.cap0 = st.count;
        if (trcc_rise(trg_c, st.trg_prev)) next_st.cap1 = st.count;
      end
      default: ;
    endcase
    // register writes; other registers locked while disabled
    if (wr && adr_i == trcc_pkg::OFS_ENABLE) begin
      next_st.enable = dat_i[ENABLE_BIT_C];
    end
    if (wr && st.enable) begin
      case (adr_i)
        trcc_pkg::OFS_RUN: begin
          next_st.prescaler_run = dat_i[PRESCALER_RUN_BIT_C];
          next_st.counter_run = dat_i[COUNTER_RUN_BIT_C];
        end
        trcc_pkg::OFS_CTRL: begin
          next_st.double_buffer_enable = dat_i[DOUBLE_BUFFER_BIT_C];
          next_st.reserved_w0 = dat_i[RESERVED_W0_BIT_C];
          next_st.sync_start_select = dat_i[SYNC_START_BIT_C];
          next_st.idle_run_enable = dat_i[IDLE_RUN_BIT_C];
        end
        trcc_pkg::OFS_MODE: begin
          if (!dat_i[SW_CAPTURE_BIT_C]) next_st.cap0 = st.count;
          next_st.capture_timing_select = dat_i[CAP_TIMING_LSB_C +: 2];
          next_st.match1_clear_enable = dat_i[MATCH1_CLEAR_BIT_C];
          next_st.clock_source_select = dat_i[CLK_SEL_LSB_C +: 2];
        end
        trcc_pkg::OFS_CMP0: begin
          next_st.cmp0_buf = dat_i[WIDTH-1:0];
          if (!st.double_buffer_enable) next_st.cmp0 = dat_i[WIDTH-1:0];
        end
        trcc_pkg::OFS_CMP1: begin
          next_st.cmp1_buf = dat_i[WIDTH-1:0];
          if (!st.double_buffer_enable) next_st.cmp1 = dat_i[WIDTH-1:0];
        end
        default: ;
      endcase
    end
    // read data, unused bits zero; reserved_w0 reads back as written
    next_st.rdata = '0;
    if (req && !we_i) begin
      if (adr_i == trcc_pkg::OFS_ENABLE) begin
        next_st.rdata[ENABLE_BIT_C] = st.enable;
      end else if (st.enable) begin
        case (adr_i)
          trcc_pkg::OFS_RUN: begin
            next_st.rdata[PRESCALER_RUN_BIT_C] = st.prescaler_run;
            next_st.rdata[COUNTER_RUN_BIT_C] = st.counter_run;
          end
          trcc_pkg::OFS_CTRL: begin
            next_st.rdata[DOUBLE_BUFFER_BIT_C] = st.double_buffer_enable;
            next_st.rdata[RESERVED_W0_BIT_C] = st.reserved_w0;
            next_st.rdata[SYNC_START_BIT_C] = st.sync_start_select;
            next_st.rdata[IDLE_RUN_BIT_C] = st.idle_run_enable;
          end
          trcc_pkg::OFS_MODE: begin
            next_st.rdata[SW_CAPTURE_BIT_C] = 1'b1;
            next_st.rdata[CAP_TIMING_LSB_C +: 2] = st.capture_timing_select;
            next_st.rdata[MATCH1_CLEAR_BIT_C] = st.match1_clear_enable;
            next_st.rdata[CLK_SEL_LSB_C +: 2] = st.clock_source_select;
          end
          trcc_pkg::OFS_COUNT: next_st.rdata[WIDTH-1:0] = st.count;
          trcc_pkg::OFS_CMP0: next_st.rdata[WIDTH-1:0] = st.cmp0_buf;
          trcc_pkg::OFS_CMP1: next_st.rdata[WIDTH-1:0] = st.cmp1_buf;
          trcc_pkg::OFS_CAP0: next_st.rdata[WIDTH-1:0] = st.cap0;
          trcc_pkg::OFS_CAP1: next_st.rdata[WIDTH-1:0] = st.cap1;
          default: ;
        endcase
      end
    end
    if (rst_i) begin
      next_st = '0;
      next_st.capture_timing_select = trcc_pkg::RESET_CAP_TIMING;
      next_st.clock_source_select = trcc_pkg::RESET_CLK_SEL;
    end
  end

  // ------------------------------------------------------------
  // registers and outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign counter_run_o = st.counter_run;
  assign count_o = st.count;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  prescaler_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.prescaler_run |=> st.prescaler == '0) else $error("prescaler not cleared");
  counter_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.counter_run && !st.sync_start_select) |=> st.count == '0)
    else $error("counter not cleared");
  direct_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && st.enable && adr_i == trcc_pkg::OFS_CMP1 && !st.double_buffer_enable)
    |=> st.cmp1 == $past(dat_i[WIDTH-1:0])) else $error("direct compare write lost");
  idle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle_mode_i && !st.idle_run_enable && st.counter_run) |=> $stable(st.count))
    else $error("counted in idle");
  sw_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && st.enable && adr_i == trcc_pkg::OFS_MODE && !dat_i[SW_CAPTURE_BIT_C])
    |=> st.cap0 == $past(st.count)) else $error("software capture missed");
  cap_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.capture_timing_select == CAP_OFF_C && !wr) |=> $stable(st.cap1))
    else $error("capture while disabled");
  match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_eff && tick && match1 && st.match1_clear_enable) |=> st.count == '0)
    else $error("no clear on match");
  mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && st.enable && adr_i == trcc_pkg::OFS_MODE)
    |=> ack_o && dat_o[SW_CAPTURE_BIT_C] && dat_o[31:7] == '0)
    else $error("mode readback wrong");
endmodule : trcc_timer

/* rtl/trcc_pkg.sv */
// package: register map, field positions and reset values of one timer channel
package trcc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_RUN = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h1C;
  localparam logic [7:0] OFS_CMP0 = 8'h20;
  localparam logic [7:0] OFS_CMP1 = 8'h24;
  localparam logic [7:0] OFS_CAP0 = 8'h28;
  localparam logic [7:0] OFS_CAP1 = 8'h2C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int PRESCALER_RUN_BIT = 2;
  localparam int COUNTER_RUN_BIT = 0;
  localparam int DOUBLE_BUFFER_BIT = 7;
  localparam int RESERVED_W0_BIT = 6;
  localparam int SYNC_START_BIT = 5;
  localparam int IDLE_RUN_BIT = 3;
  localparam int SW_CAPTURE_BIT = 5;
  localparam int CAP_TIMING_LSB = 3;
  localparam int MATCH1_CLEAR_BIT = 2;
  localparam int CLK_SEL_LSB = 0;
  // ------------------------------------------------------------
  // field codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_IN0_IN1 = 2'h1;
  localparam logic [1:0] CAP_IN0_BOTH = 2'h2;
  localparam logic [1:0] CAP_MATCH = 2'h3;
  localparam logic [1:0] CLK_PIN = 2'h0;
  localparam logic [1:0] CLK_T1 = 2'h1;
  localparam logic [1:0] CLK_T4 = 2'h2;
  localparam logic [1:0] CLK_T16 = 2'h3;
  localparam logic [1:0] RESET_CAP_TIMING = 2'h0;
  localparam logic [1:0] RESET_CLK_SEL = 2'h0;
  localparam int PRESCALER_WIDTH = 4;
  localparam int TAP_T4 = 1;
  localparam int TAP_T16 = 3;
endpackage : trcc_pkg

/* tb/trcc_pin_model.sv */
// partner model: capture pins and neighbouring match outputs seen by one channel
`timescale 1ns/1ps
module trcc_pin_model (
  input wire logic clk_i,
  output logic capture_input_0_o,
  output logic capture_input_1_o,
  output logic [2:0] match_o
);
  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  // all lines idle low from time zero
  initial begin
    capture_input_0_o = 1'b0;
    capture_input_1_o = 1'b0;
    match_o = 3'h0;
  end
  // move one line just after an edge, then wait out the 2-ff sync and edge detect
  // index 0/1 are the capture pins, 2..4 the channel 7, 8 and 9 match outputs
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    case (idx)
      0: capture_input_0_o <= v;
      1: capture_input_1_o <= v;
      default: match_o[idx-2] <= v;
    endcase
    repeat (6) @(posedge clk_i);
  endtask : set_pin
endmodule : trcc_pin_model

/* tb/trcc_timer_tb_top.sv */
// testbench: register access, run control, count clocks and capture of one channel
`timescale 1ns/1ps
module trcc_timer_tb_top;
  localparam logic [7:0] ENA = trcc_pkg::OFS_ENABLE;
  localparam logic [7:0] RUN = trcc_pkg::OFS_RUN;
  localparam logic [7:0] CTL = trcc_pkg::OFS_CTRL;
  localparam logic [7:0] MOD = trcc_pkg::OFS_MODE;
  localparam logic [7:0] CM1 = trcc_pkg::OFS_CMP1;
  localparam logic [7:0] CP0 = trcc_pkg::OFS_CAP0;
  localparam logic [7:0] CP1 = trcc_pkg::OFS_CAP1;
  localparam logic [7:0] FA [3] = '{CTL, RUN, MOD};
  localparam logic [31:0] FE [3] = '{32'hA8, 32'h5, 32'h3F};
  localparam logic [31:0] FZ [3] = '{32'h0, 32'h0, 32'h20};
  logic clk_i;
  logic rst_i;
  logic cyc, stb, we, ack, idle, mrun, crun, in0, in1;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] cnt, mx;
  logic [2:0] mt;
  int failures;
  int checks;
  // channel 1: not a group master, capture trigger comes from channel 7
  trcc_timer #(.CHANNEL(1), .WIDTH(16)) u_trcc_timer (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .idle_mode_i(idle),
    .master_run_i(mrun), .capture_input_0_i(in0), .capture_input_1_i(in1),
    .channel7_match_output_i(mt[0]), .channel8_match_output_i(mt[1]),
    .channel9_match_output_i(mt[2]), .counter_run_o(crun), .count_o(cnt));
  trcc_pin_model u_trcc_pin_model (.clk_i(clk_i), .capture_input_0_o(in0),
    .capture_input_1_o(in1), .match_o(mt));
  // free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled; bounded so a dead slave ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      $display("BAD %0t no ack", $time);
      final_report();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic pin(input int i, input logic v);
    u_trcc_pin_model.set_pin(i, v);
  endtask : pin
  // one rising and falling edge on capture input 0, which is also the pin clock
  task automatic pulse0;
    pin(0, 1'b1);
    pin(0, 1'b0);
  endtask : pulse0
  // counter advance over 32 clocks, a whole number of every prescaler period
  task automatic rate(input logic [15:0] e);
    logic [15:0] c;
    repeat (4) @(posedge clk_i);
    c = cnt;
    repeat (32) @(posedge clk_i);
    chk({16'h0000, cnt - c}, {16'h0000, e});
  endtask : rate
  // highest count seen over 40 clocks
  task automatic peak;
    mx = 16'h0000;
    repeat (40) begin
      @(posedge clk_i);
      if (cnt > mx) begin
        mx = cnt;
      end
    end
  endtask : peak
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    // while disabled every register but enable reads zero
    rd(ENA, 32'h0);
    rd(RUN, 32'h0);
    wr(RUN, 32'h5);
    wr(ENA, 32'h80);
    rd(ENA, 32'h80);
    rd(RUN, 32'h0);
    rd(CTL, 32'h0);
    rd(MOD, 32'h20);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(FA[i], 32'hFFFFFFBF);
      rd(FA[i], FE[i]);
      wr(FA[i], FZ[i]);
    end
  endtask : t_regs
  task automatic t_rate;
    for (int c = 1; c < 4; c++) begin
      wr(MOD, 32'h20 + 32'(c));
      wr(RUN, 32'h5);
      chk({31'h0, crun}, 32'h1);
      rate(16'(32 >> (2 * (c - 1))));
      wr(RUN, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({16'h0, cnt}, 32'h0);
    end
    wr(RUN, 32'h1);
    rate(16'h0);
    wr(RUN, 32'h0);
  endtask : t_rate
  task automatic t_idle_sync;
    // count on every clock so the expected rates are whole
    wr(MOD, 32'h21);
    idle <= 1'b1;
    wr(RUN, 32'h5);
    rate(16'h0);
    wr(CTL, 32'h8);
    rate(16'h20);
    wr(RUN, 32'h0);
    idle <= 1'b0;
    wr(CTL, 32'h20);
    wr(RUN, 32'h5);
    rate(16'h0);
    mrun <= 1'b1;
    rate(16'h20);
    wr(RUN, 32'h0);
    wr(CTL, 32'h0);
    mrun <= 1'b0;
  endtask : t_idle_sync
  task automatic t_clear;
    wr(CM1, 32'hA);
    wr(MOD, 32'h25);
    wr(RUN, 32'h5);
    peak();
    chk({16'h0, mx}, 32'hA);
    wr(RUN, 32'h0);
    wr(MOD, 32'h21);
    wr(RUN, 32'h5);
    peak();
    chk({31'h0, mx > 16'hA}, 32'h1);
    wr(RUN, 32'h0);
    wr(CTL, 32'h80);
    wr(CM1, 32'h4);
    wr(MOD, 32'h25);
    wr(RUN, 32'h5);
    peak();
    chk({16'h0, mx}, 32'hA);
    peak();
    chk({16'h0, mx}, 32'h4);
    wr(RUN, 32'h0);
    wr(CTL, 32'h0);
  endtask : t_clear
  // pin clock holds the count still between in0 rises, so captures are exact
  task automatic t_cap;
    wr(MOD, 32'h28);
    wr(RUN, 32'h1);
    repeat (3) pulse0();
    chk({16'h0, cnt}, 32'h3);
    wb(1'b0, CP0, 32'h0);
    chk({31'h0, q == 32'h2 || q == 32'h3}, 32'h1);
    pin(1, 1'b1);
    rd(CP1, 32'h3);
    wr(MOD, 32'h30);
    pulse0();
    rd(CP1, 32'h4);
    wr(MOD, 32'h38);
    pin(2, 1'b1);
    rd(CP0, 32'h4);
    pulse0();
    pin(3, 1'b1);
    pin(3, 1'b0);
    rd(CP0, 32'h4);
    pin(2, 1'b0);
    rd(CP1, 32'h5);
    wr(MOD, 32'h20);
    pin(2, 1'b1);
    pin(1, 1'b0);
    pulse0();
    rd(CP0, 32'h4);
    rd(CP1, 32'h5);
    wr(MOD, 32'h0);
    rd(CP0, 32'h6);
    wr(RUN, 32'h0);
  endtask : t_cap
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    idle = 1'b0;
    mrun = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_rate();
    t_idle_sync();
    t_clear();
    t_cap();
    final_report();
  end
endmodule : trcc_timer_tb_top
